// ---- test/nv_command_sequence_decoder_test.sv ----
/*
  Self-checking bench for the command-series host controller.
  Assumes the design package and the device model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module nv_command_sequence_decoder_test;
  typedef struct {
    nv_seq_pkg::cmd_e cmd;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } row_s;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic low_supply_i = 1'b0;
  nv_seq_pkg::host_req_s req_i = '0;
  logic req_ready_o, done_o, error_o, dq_oe_o, busy_o, busy_oe, busy_pull, power_loss_save_o;
  logic [15:0] rdata_o, dq_o, model_dq, dq_bus;
  nv_seq_pkg::mem_ctrl_s mem_o;
  logic busy_wire;
  logic busy_seen = 1'b0;
  logic err_seen = 1'b0;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  row_s rows [6] = '{
    '{nv_seq_pkg::CMD_WRITE, 18'h00010, 16'hA5A5, 16'h0000},
    '{nv_seq_pkg::CMD_READ, 18'h00010, 16'h0000, 16'hA5A5},
    '{nv_seq_pkg::CMD_READ, 18'h00020, 16'h0000, 16'h0000},
    '{nv_seq_pkg::CMD_WRITE, 18'h0703F, 16'h5A5A, 16'h0000},
    '{nv_seq_pkg::CMD_WRITE, 18'h08FC0, 16'hFFFF, 16'h0000},
    '{nv_seq_pkg::CMD_READ, 18'h3FFFF, 16'h0000, 16'h0000}};
  assign dq_bus = dq_oe_o ? dq_o : model_dq;
  assign busy_wire = !busy_pull && !(busy_oe && !busy_o);
  nv_seq_host #(.RESTORE_CYC(20), .HOLD_CYC(5), .BUSY_TIMEOUT(200)) DUT (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
    .low_supply_i(low_supply_i), .done_o(done_o), .error_o(error_o), .rdata_o(rdata_o), .mem_o(mem_o),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_bus), .store_busy_line_n_i(busy_wire),
    .store_busy_line_n_o(busy_o), .store_busy_line_n_oe_o(busy_oe), .power_loss_save_o(power_loss_save_o));
  nv_sram_model model (.clk_sys_i(clk_sys_i), .mem_i(mem_o), .dq_i(dq_bus), .busy_n_i(busy_wire),
    .dq_o(model_dq), .busy_pull_o(busy_pull));
  always #50 clk_sys_i = ~clk_sys_i;
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic issue(input nv_seq_pkg::cmd_e c, input logic [17:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_i <= '{cmd: c, addr: a, wdata: d};
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    n = 0;
    @(negedge clk_sys_i);
    while (done_o !== 1'b1 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
    end
    err_seen = error_o;
    chk("done", 16'h0001, {15'h0000, done_o});
  endtask : issue
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (busy_wire === 1'b0) busy_seen <= 1'b1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("pls reset", 16'h0001, {15'h0000, power_loss_save_o});
    chk("cs idle", 16'h0001, {15'h0000, mem_o.cs_n});
    chk("ready idle", 16'h0001, {15'h0000, req_ready_o});
    chk("busy oe", 16'h0000, {15'h0000, busy_oe});
    // Clock enable low: a waiting request must not be taken
    @(posedge clk_sys_i);
    clk_en_i <= 1'b0;
    req_valid_i <= 1'b1;
    req_i <= '{cmd: nv_seq_pkg::CMD_READ, addr: 18'h00010, wdata: 16'h0000};
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("frozen ready", 16'h0001, {15'h0000, req_ready_o});
    chk("frozen cs", 16'h0001, {15'h0000, mem_o.cs_n});
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    clk_en_i <= 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].cmd, rows[i].addr, rows[i].wdata);
      chk("row error", 16'h0000, {15'h0000, err_seen});
      if (rows[i].cmd == nv_seq_pkg::CMD_READ) chk("row data", rows[i].rdata, rdata_o);
    end
    issue(nv_seq_pkg::CMD_SAVE, 18'h00000, 16'h0000);
    chk("busy seen", 16'h0001, {15'h0000, busy_seen});
    chk("saved word", 16'hA5A5, model.nv[18'h00010]);
    chk("sixth read", 16'h5A5A, rdata_o);
    issue(nv_seq_pkg::CMD_WRITE, 18'h00010, 16'h0F0F);
    issue(nv_seq_pkg::CMD_READ, 18'h00010, 16'h0000);
    chk("write after hold", 16'h0F0F, rdata_o);
    issue(nv_seq_pkg::CMD_WRITE, 18'h00030, 16'h7777);
    issue(nv_seq_pkg::CMD_RESTORE, 18'h00000, 16'h0000);
    chk("nv kept", 16'hA5A5, model.nv[18'h00010]);
    issue(nv_seq_pkg::CMD_READ, 18'h00010, 16'h0000);
    chk("restored", 16'hA5A5, rdata_o);
    issue(nv_seq_pkg::CMD_READ, 18'h00030, 16'h0000);
    chk("cleared", 16'h0000, rdata_o);
    issue(nv_seq_pkg::CMD_PLS_OFF, 18'h00000, 16'h0000);
    chk("pls off", 16'h0000, {15'h0000, power_loss_save_o});
    chk("model pls off", 16'h0000, {15'h0000, model.pls});
    // Reset in the middle of a read
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_i <= '{cmd: nv_seq_pkg::CMD_READ, addr: 18'h00010, wdata: 16'h0000};
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("cs after reset", 16'h0001, {15'h0000, mem_o.cs_n});
    chk("ready after reset", 16'h0001, {15'h0000, req_ready_o});
    chk("pls after reset", 16'h0001, {15'h0000, power_loss_save_o});
    issue(nv_seq_pkg::CMD_SAVE, 18'h00000, 16'h0000);
    issue(nv_seq_pkg::CMD_PLS_ON, 18'h00000, 16'h0000);
    chk("pls on", 16'h0001, {15'h0000, power_loss_save_o});
    chk("model pls on", 16'h0001, {15'h0000, model.pls});
    issue(nv_seq_pkg::CMD_SAVE, 18'h00000, 16'h0000);
    @(posedge clk_sys_i);
    low_supply_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    issue(nv_seq_pkg::CMD_WRITE, 18'h00010, 16'h1111);
    chk("low write", 16'h0001, {15'h0000, err_seen});
    issue(nv_seq_pkg::CMD_SAVE, 18'h00000, 16'h0000);
    chk("low save", 16'h0001, {15'h0000, err_seen});
    @(posedge clk_sys_i);
    low_supply_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    issue(nv_seq_pkg::CMD_READ, 18'h00010, 16'h0000);
    chk("kept word", 16'hA5A5, rdata_o);
    conclude();
  end
endmodule : nv_command_sequence_decoder_test
`default_nettype wire

// ---- test/nv_sram_model.sv ----
/*
  Behavioural model of the non-volatile SRAM on the far side of the host.
  Assumes the bench resolves the open-drain busy line and the data bus.
*/
`timescale 1ns/1ns
`default_nettype none
`include "nv_seq_consts.svh"
module nv_sram_model #(
  parameter int SAVE_CYC = 30,
  parameter int RESTORE_CYC = 20,
  parameter int HOLD_CYC = 4
) (
  input wire logic clk_sys_i,
  input wire nv_seq_pkg::mem_ctrl_s mem_i,
  input wire logic [15:0] dq_i,
  input wire logic busy_n_i,
  output logic [15:0] dq_o,
  output logic busy_pull_o
);
  bit [15:0] sram [logic [17:0]];
  bit [15:0] nv [logic [17:0]];
  logic [17:0] pfx [5] = '{`NV_PFX0, `NV_PFX1, `NV_PFX2, `NV_PFX3, `NV_PFX4};
  logic pls = 1'b1;
  int pos = 0;
  int bcnt = 0;
  int rcnt = 0;
  int hcnt = 0;
  logic rd_q = 1'b0;
  logic [15:0] last = 16'h0000;
  logic rd;
  logic wr;
  logic sixth;
  function automatic logic match(input logic [17:0] a);
    return ((mem_i.addr ^ a) & `NV_CMP_MASK) == 18'h00000;
  endfunction : match
  assign rd = !mem_i.cs_n && !mem_i.oe_n && mem_i.we_n && busy_n_i && rcnt == 0;
  assign wr = !mem_i.cs_n && !mem_i.we_n && busy_n_i && rcnt == 0 && hcnt == 0;
  always_comb sixth = pos == 5 && (match(`NV_CMD_SAVE) || match(`NV_CMD_RESTORE));
  assign busy_pull_o = bcnt != 0;
  // Released bus shows a changing pattern, never the last value
  always_comb dq_o = (rd && !sixth) ? (sram.exists(mem_i.addr) ? sram[mem_i.addr] : 16'h0000) : ~last;
  always @(posedge clk_sys_i) begin
    last <= dq_o;
    rd_q <= rd;
    if (bcnt != 0) bcnt <= bcnt - 1;
    if (rcnt != 0) rcnt <= rcnt - 1;
    // Writes stay locked out for a while once a save or restore ends
    if (bcnt == 1 || rcnt == 1) hcnt <= HOLD_CYC;
    else if (hcnt != 0) hcnt <= hcnt - 1;
    if (wr) begin
      sram[mem_i.addr] = dq_i;
      pos <= 0;
    end else if (rd && !rd_q) begin
      if (pos == 5 && match(`NV_CMD_SAVE)) begin
        nv = sram;
        bcnt <= SAVE_CYC;
      end
      if (pos == 5 && match(`NV_CMD_RESTORE)) begin
        sram.delete();
        sram = nv;
        rcnt <= RESTORE_CYC;
      end
      if (pos == 5 && match(`NV_CMD_PLS_OFF)) pls <= 1'b0;
      if (pos == 5 && match(`NV_CMD_PLS_ON)) pls <= 1'b1;
      pos <= (pos < 5 && match(pfx[pos])) ? pos + 1 : int'(match(pfx[0]));
    end
  end
endmodule : nv_sram_model
`default_nettype wire

// ---- verilog/nv_seq_consts.svh ----
/*
  Constants for the host-side command-series controller of a non-volatile SRAM.
  Assumes it is included by the package, the controller and the device model.
*/
// Operation
// R1: Sixth read at restore code address starts a restore.
// R2: Series is five prefix reads in fixed order, then the command address.
// R3: Host keeps write strobe high through all six reads.
// R4: Device restore clears SRAM, then copies non-volatile cells in.
// R5: Device blocks reads and writes for the restore time.
// R6: Restore leaves non-volatile cells unchanged.
// R7: Only address bits 14 to 2 matter for series matching.
// R8: Sixth read at disable code address turns off power-loss save.
// R9: Sixth read at enable code address turns power-loss save back on.
// R10: After changing power-loss save setting, a manual save must follow.
// R11: Device ships with power-loss save on and all cells zero.
// R12: Prefix reads return data; sixth read of save or restore floats outputs.
// R13: Saves and writes are blocked while supply is low.
// R14: Write active at power-up or after busy waits for post-busy hold time. Host and model hold only after a save or restore, not at power-up.
// R15: Host issues every series as chip-select or output-enable controlled reads.
// R16: Any other access aborts a partly entered series.
// R17: A read is chip select and output enable low, write and busy high.
// R18: Sixth read at save code address starts a save; busy line low until done.
// R19: Mismatching read restarts the series and is rechecked as first step.
// R20: Low supply is an input flag; restore and hold times are counts.
`ifndef NV_SEQ_CONSTS_SVH
`define NV_SEQ_CONSTS_SVH
`define NV_ADDR_W 18
`define NV_DATA_W 16
`define NV_PFX0 18'h04E38
`define NV_PFX1 18'h0B1C7
`define NV_PFX2 18'h083E0
`define NV_PFX3 18'h07C1F
`define NV_PFX4 18'h0703F
`define NV_CMD_SAVE 18'h08FC0
`define NV_CMD_RESTORE 18'h04C63
`define NV_CMD_PLS_OFF 18'h08B45
`define NV_CMD_PLS_ON 18'h04B46
`define NV_CMP_MASK 18'h07FFC
`define NV_CLK_PERIOD_NS 100
`define NV_ACCESS_NS 100
`define NV_ACCESS_CYC ((`NV_ACCESS_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_RESTORE_NS 200000
`define NV_RESTORE_CYC ((`NV_RESTORE_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_HOLD_NS 20000
`define NV_HOLD_CYC ((`NV_HOLD_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_BUSY_TIMEOUT_CYC 100000
`endif

// ---- verilog/nv_seq_host.sv ----
/*
  Host controller: runs plain reads and writes and six-read command series on a
  non-volatile SRAM. Assumes the memory pins are sampled on clk_sys_i (10 MHz).
*/
`timescale 1ns/1ns
`default_nettype none
`include "nv_seq_consts.svh"
module nv_seq_host #(
  parameter int RESTORE_CYC = `NV_RESTORE_CYC,
  parameter int HOLD_CYC = `NV_HOLD_CYC,
  parameter int BUSY_TIMEOUT = `NV_BUSY_TIMEOUT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire nv_seq_pkg::host_req_s req_i,
  input wire logic low_supply_i,
  output logic done_o,
  output logic error_o,
  output logic [`NV_DATA_W-1:0] rdata_o,
  output nv_seq_pkg::mem_ctrl_s mem_o,
  output logic [`NV_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [`NV_DATA_W-1:0] dq_i,
  input wire logic store_busy_line_n_i,
  output logic store_busy_line_n_o,
  output logic store_busy_line_n_oe_o,
  output logic power_loss_save_o
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] busy_sync;
  logic busy_n;
  logic low_sync0;
  logic low_supply;
  logic [`NV_DATA_W-1:0] dq_s0;
  logic [`NV_DATA_W-1:0] dq_s1;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_sync <= 2'h3;
      low_sync0 <= 1'b0;
      low_supply <= 1'b0;
      dq_s0 <= '0;
      dq_s1 <= '0;
    end else if (clk_en_i) begin
      busy_sync <= {busy_sync[0], store_busy_line_n_i};
      low_sync0 <= low_supply_i;
      low_supply <= low_sync0; // [R20]
      dq_s0 <= dq_i;
      dq_s1 <= dq_s0;
    end
  end
  assign busy_n = busy_sync[1];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`NV_ADDR_W-1:0] step_addr(input logic [2:0] idx,
                                                      input nv_seq_pkg::cmd_e cmd);
    case (idx)
      3'h0: step_addr = `NV_PFX0;
      3'h1: step_addr = `NV_PFX1;
      3'h2: step_addr = `NV_PFX2;
      3'h3: step_addr = `NV_PFX3;
      3'h4: step_addr = `NV_PFX4;
      default: begin
        case (cmd)
          nv_seq_pkg::CMD_SAVE: step_addr = `NV_CMD_SAVE; // [R18]
          nv_seq_pkg::CMD_RESTORE: step_addr = `NV_CMD_RESTORE; // [R1]
          nv_seq_pkg::CMD_PLS_OFF: step_addr = `NV_CMD_PLS_OFF; // [R8]
          default: step_addr = `NV_CMD_PLS_ON; // [R9]
        endcase
      end
    endcase
  endfunction : step_addr

  function automatic logic is_series(input nv_seq_pkg::cmd_e cmd);
    is_series = (cmd != nv_seq_pkg::CMD_READ) && (cmd != nv_seq_pkg::CMD_WRITE);
  endfunction : is_series

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam int CW = 32;
  nv_seq_pkg::state_e state, next_state;
  nv_seq_pkg::host_req_s cur, next_cur;
  logic [2:0] step, next_step;
  logic [CW-1:0] cnt, next_cnt;
  logic [`NV_ADDR_W-1:0] addr, next_addr;
  logic cs_n, next_cs_n;
  logic oe_n, next_oe_n;
  logic we_n, next_we_n;
  logic dq_oe, next_dq_oe;
  logic done, next_done;
  logic err, next_err;
  logic pls, next_pls;
  logic pls_dirty, next_pls_dirty;
  logic [`NV_DATA_W-1:0] rdata, next_rdata;
  logic is_wr;

  assign is_wr = (cur.cmd == nv_seq_pkg::CMD_WRITE);

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_step = step;
    next_cnt = cnt;
    next_addr = addr;
    next_cs_n = cs_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_dq_oe = dq_oe;
    next_done = 1'b0;
    next_err = 1'b0;
    next_pls = pls;
    next_pls_dirty = pls_dirty;
    next_rdata = rdata;
    case (state)
      nv_seq_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          next_cur = req_i;
          next_step = 3'h0;
          next_cnt = '0;
          if (req_i.cmd == nv_seq_pkg::CMD_WRITE && low_supply) begin
            next_err = 1'b1; // [R13]
            next_done = 1'b1;
          end else if (req_i.cmd == nv_seq_pkg::CMD_SAVE && low_supply) begin
            next_err = 1'b1; // [R13]
            next_done = 1'b1;
          end else begin
            next_state = nv_seq_pkg::ST_BUSY_WAIT;
          end
        end
      end
      nv_seq_pkg::ST_BUSY_WAIT: begin
        // Accesses only start with the busy line high [R17] [R14]
        if (busy_n) begin
          next_state = nv_seq_pkg::ST_ACC;
          next_cnt = '0;
          next_cs_n = 1'b0;
          next_we_n = ~is_wr; // [R3]
          next_oe_n = is_wr; // [R15]
          next_dq_oe = is_wr;
          next_addr = is_series(cur.cmd) ? step_addr(step, cur.cmd) : cur.addr; // [R2] [R7]
        end
      end
      nv_seq_pkg::ST_ACC: begin
        next_cnt = cnt + CW'(1);
        // One extra cycle so the read word has crossed both sync flops
        if (cnt >= CW'(`NV_ACCESS_CYC + 1)) begin
          if (!is_wr && step != 3'h5) next_rdata = dq_s1; // [R12]
          next_cs_n = 1'b1;
          next_oe_n = 1'b1;
          next_we_n = 1'b1;
          next_dq_oe = 1'b0;
          next_cnt = '0;
          next_state = nv_seq_pkg::ST_GAP;
        end
      end
      nv_seq_pkg::ST_GAP: begin
        // Series reads follow each other with nothing between [R16] [R19]
        if (is_series(cur.cmd) && step != 3'h5) begin
          next_step = step + 3'h1;
          next_state = nv_seq_pkg::ST_BUSY_WAIT;
        end else if (cur.cmd == nv_seq_pkg::CMD_SAVE) begin
          next_state = nv_seq_pkg::ST_TIMED; // [R18]
          next_pls_dirty = 1'b0; // [R10]
        end else if (cur.cmd == nv_seq_pkg::CMD_RESTORE) begin
          next_state = nv_seq_pkg::ST_TIMED; // [R5]
        end else if (is_series(cur.cmd)) begin
          next_pls = (cur.cmd == nv_seq_pkg::CMD_PLS_ON); // [R8] [R9]
          next_pls_dirty = 1'b1; // [R10]
          next_state = nv_seq_pkg::ST_DONE;
        end else begin
          next_state = nv_seq_pkg::ST_DONE;
        end
      end
      nv_seq_pkg::ST_TIMED: begin
        next_cnt = cnt + CW'(1);
        if (cur.cmd == nv_seq_pkg::CMD_RESTORE ? cnt >= CW'(RESTORE_CYC) : (busy_n && cnt > CW'(4))) begin
          next_cnt = '0;
          next_state = nv_seq_pkg::ST_HOLD;
        end else if (cnt >= CW'(BUSY_TIMEOUT)) begin
          next_err = 1'b1;
          next_cnt = '0;
          next_state = nv_seq_pkg::ST_HOLD;
        end
      end
      nv_seq_pkg::ST_HOLD: begin
        next_cnt = cnt + CW'(1);
        if (cnt >= CW'(HOLD_CYC)) next_state = nv_seq_pkg::ST_DONE; // [R14]
      end
      nv_seq_pkg::ST_DONE: begin
        next_done = 1'b1;
        next_state = nv_seq_pkg::ST_IDLE;
      end
      default: next_state = nv_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state <= nv_seq_pkg::ST_IDLE;
      cur <= '0;
      step <= 3'h0;
      cnt <= '0;
      addr <= '0;
      cs_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      pls <= 1'b1; // [R11]
      pls_dirty <= 1'b0;
      rdata <= '0;
    end else if (clk_en_i) begin
      state <= next_state;
      cur <= next_cur;
      step <= next_step;
      cnt <= next_cnt;
      addr <= next_addr;
      cs_n <= next_cs_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      dq_oe <= next_dq_oe;
      done <= next_done;
      err <= next_err;
      pls <= next_pls;
      pls_dirty <= next_pls_dirty;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready_o = (state == nv_seq_pkg::ST_IDLE);
  assign done_o = done;
  assign error_o = err;
  assign rdata_o = rdata;
  assign mem_o = '{cs_n: cs_n, oe_n: oe_n, we_n: we_n, upper_byte_lane_n: cs_n,
                   lower_byte_lane_n: cs_n, addr: addr};
  assign dq_o = cur.wdata;
  assign dq_oe_o = dq_oe;
  assign store_busy_line_n_o = 1'b0;
  assign store_busy_line_n_oe_o = 1'b0;
  assign power_loss_save_o = pls;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_series_we_high: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R3]
    (!cs_n && is_series(cur.cmd)) |-> we_n && !oe_n)
    else $error("write strobe low during command series");
  a_write_not_low: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R13]
    (state == nv_seq_pkg::ST_IDLE && req_valid_i && low_supply && req_i.cmd == nv_seq_pkg::CMD_WRITE && clk_en_i)
    |=> err && state == nv_seq_pkg::ST_IDLE)
    else $error("write issued under low supply");
  a_no_dq_on_read: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R12]
    (!oe_n) |-> !dq_oe)
    else $error("host drives data during read");
  a_prefix_addr: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R2]
    ($fell(cs_n) && is_series(cur.cmd) && step == 3'h0) |-> addr == `NV_PFX0)
    else $error("series does not start at first prefix");
  a_dirty_until_save: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R10]
    (state == nv_seq_pkg::ST_GAP && step == 3'h5 && clk_en_i &&
     (cur.cmd == nv_seq_pkg::CMD_PLS_OFF || cur.cmd == nv_seq_pkg::CMD_PLS_ON)) |=> pls_dirty)
    else $error("setting change not marked for a later save");
endmodule : nv_seq_host
`default_nettype wire

// ---- verilog/nv_seq_pkg.sv ----
/*
  Types for the command-series controller.
  Assumes the constants header is on the include path.
*/
`default_nettype none
`include "nv_seq_consts.svh"
package nv_seq_pkg;
  typedef enum logic [2:0] {
    CMD_SAVE = 3'h0,
    CMD_RESTORE = 3'h1,
    CMD_PLS_OFF = 3'h2,
    CMD_PLS_ON = 3'h3,
    CMD_READ = 3'h4,
    CMD_WRITE = 3'h5
  } cmd_e;
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic upper_byte_lane_n;
    logic lower_byte_lane_n;
    logic [`NV_ADDR_W-1:0] addr;
  } mem_ctrl_s;
  typedef struct packed {
    cmd_e cmd;
    logic [`NV_ADDR_W-1:0] addr;
    logic [`NV_DATA_W-1:0] wdata;
  } host_req_s;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ACC = 7'h02,
    ST_GAP = 7'h04,
    ST_BUSY_WAIT = 7'h08,
    ST_TIMED = 7'h10,
    ST_HOLD = 7'h20,
    ST_DONE = 7'h40
  } state_e;
endpackage : nv_seq_pkg
`default_nettype wire
